// ===== hdl/eac_map.svh
// register offsets, field positions, reset values and timing of the nv access controller
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH
// device register offsets in io space
`define EAC_IO_AW 6
`define EAC_OFS_CTRL 6'h1F
`define EAC_OFS_DATA 6'h20
`define EAC_OFS_ADDR_LO 6'h21
`define EAC_OFS_ADDR_HI 6'h22
// control register fields
`define EAC_CTRL_READ 0
`define EAC_CTRL_PROG 1
`define EAC_CTRL_ARM 2
`define EAC_CTRL_MODE_LSB 4
`define EAC_CTRL_MODE_MSB 5
// reset values
`define EAC_RST_DATA 8'h00
`define EAC_RST_MODE 2'h0
// array geometry
`define EAC_NV_BYTES 4096
`define EAC_PAGE_BYTES 8
`define EAC_ERASED 8'hFF
// core stall and arm window, in clock cycles
`define EAC_STALL_READ 3'h4
`define EAC_STALL_PROG 3'h2
`define EAC_ARM_WINDOW 3'h4
// programming time base
`define EAC_CLK_MHZ 250
`define EAC_OSC_TICK_US 1
`define EAC_T_WRITE_MS 4.5
`define EAC_T_ERASE_MS 8.5
`define EAC_T_LOAD_US 1
// host software register offsets and fields
`define EAC_SW_AW 3
`define EAC_SW_CMD 3'h0
`define EAC_SW_ADDR_LO 3'h1
`define EAC_SW_ADDR_HI 3'h2
`define EAC_SW_DATA 3'h3
`define EAC_SW_STATUS 3'h4
`define EAC_CMD_READ 2
`define EAC_ST_BUSY 0
`define EAC_ST_FLASH_WAIT 1
`endif

// ===== hdl/eac_pkg.sv
// shared types of the nv access controller
package eac_pkg;
  typedef logic [7:0] eac_byte_t;
  typedef enum logic [1:0] {
    eac_mode_both = 2'h0,
    eac_mode_erase = 2'h1,
    eac_mode_write = 2'h2,
    eac_mode_load = 2'h3
  } eac_mode_e;
endpackage

// ===== hdl/eac_io_if.sv
// io register port between the core side and the nv access controller
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
interface eac_io_if;
  logic [`EAC_IO_AW-1:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_stall;
  modport dev(input io_addr, io_wr, io_rd, io_wdata, output io_rdata, io_stall);
  modport cpu(output io_addr, io_wr, io_rd, io_wdata, input io_rdata, io_stall);
endinterface
`default_nettype wire

// ===== hdl/eac_prog_timer.sv
// self-timed programming engine clocked from the calibrated oscillator tick
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
module eac_prog_timer import eac_pkg::*; #(
  parameter int unsigned OSC_DIV = 250,
  parameter int unsigned T_ERASE = 8500,
  parameter int unsigned T_WRITE = 4500,
  parameter int unsigned T_LOAD = 1
) (
  input wire logic clk,
  input wire logic por_n,
  input wire logic start,
  input wire eac_mode_e mode,
  output logic busy,
  output logic done
);
  localparam int unsigned TW = $clog2(T_ERASE + T_WRITE + 1);
  localparam int unsigned DW = $clog2(OSC_DIV + 1);

  if (OSC_DIV < 1 || T_ERASE < 1 || T_WRITE < 1 || T_LOAD < 1) begin : g_chk
    $error("eac_prog_timer: divider and durations must be at least one");
  end

  logic [DW-1:0] div_q;
  logic [TW-1:0] left_q;
  logic busy_q;
  logic tick;

  function automatic logic [TW-1:0] ticks_for(eac_mode_e m);
    unique case (m)
      eac_mode_erase: ticks_for = TW'(T_ERASE);
      eac_mode_write: ticks_for = TW'(T_WRITE);
      eac_mode_load: ticks_for = TW'(T_LOAD);
      eac_mode_both: ticks_for = TW'(T_ERASE + T_WRITE);
    endcase
  endfunction

  assign tick = (div_q == DW'(OSC_DIV - 1));

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'h1;
    end
  end

  // only power-on reset stops a running operation
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      busy_q <= 1'h0;
      left_q <= '0;
    end else if (start && !busy_q) begin
      busy_q <= 1'h1;
      left_q <= ticks_for(mode);
    end else if (busy_q && tick) begin
      busy_q <= (left_q != TW'(1));
      left_q <= left_q - 1'h1;
    end
  end

  assign busy = busy_q;
  assign done = busy_q && tick && (left_q == TW'(1));
endmodule
`default_nettype wire

// ===== hdl/eac_nv_device.sv
// byte-wide data eeprom with its io-space access controller
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
// Notes on behaviour
// - array of 8K, 4K or 2K bytes
// - reads are single bytes only
// - address, data, control reachable in io space
// - read stalls the core four cycles
// - erase or write stalls core two cycles
// - program strobe reads set until done
// - programming timed from oscillator tick
// - write only takes about 4.5 ms
// - erase takes about 8.5 ms
// - strobe needs arm written beforehand
// - mode 1 erases, mode 2 writes
// - software polls strobe clear before access
// - write uses address registers and data
// - read strobe loads data register
// - separate erase and write preferred
// - wait for flash self programming first
// - no interrupts between arm and strobe
// - mode field sits in bits 5:4
// - mode 3 only loads page buffer
// - address register has no reset value
// - reset does not abort running write
module eac_nv_device import eac_pkg::*; #(
  parameter int unsigned NV_BYTES = `EAC_NV_BYTES,
  parameter int unsigned OSC_DIV = `EAC_CLK_MHZ * `EAC_OSC_TICK_US,
  parameter int unsigned T_WRITE_TICKS = int'(`EAC_T_WRITE_MS * 1000.0 / `EAC_OSC_TICK_US),
  parameter int unsigned T_ERASE_TICKS = int'(`EAC_T_ERASE_MS * 1000.0 / `EAC_OSC_TICK_US),
  parameter int unsigned T_LOAD_TICKS = `EAC_T_LOAD_US / `EAC_OSC_TICK_US
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  eac_io_if.dev io,
  output logic prog_busy
);
  localparam int unsigned AW = $clog2(NV_BYTES);
  localparam int unsigned HW = AW - 8;
  localparam int unsigned PAGE = `EAC_PAGE_BYTES;
  localparam int unsigned PW = $clog2(PAGE);

  if (NV_BYTES != 2048 && NV_BYTES != 4096 && NV_BYTES != 8192) begin : g_chk
    $error("eac_nv_device: NV_BYTES must be 2048, 4096 or 8192");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  eac_byte_t mem_q [NV_BYTES];
  eac_byte_t pbuf_q [PAGE];
  logic [PAGE-1:0] pvld_q;
  logic [AW-PW-1:0] pg_q;
  eac_mode_e run_mode_q;

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [AW-1:0] addr_q;
  eac_byte_t data_q;
  eac_byte_t rdata_q;
  eac_byte_t rd_mux;
  eac_mode_e mode_q;
  eac_mode_e wr_mode;
  logic [2:0] arm_cnt_q;
  logic [2:0] stall_q;
  logic rst_meta_q;
  logic rst_sync_q;
  logic busy;
  logic done;
  logic ctrl_wr;
  logic prog_go;
  logic read_go;

  assign ctrl_wr = io.io_wr && (io.io_addr == `EAC_OFS_CTRL);
  assign wr_mode = eac_mode_e'(io.io_wdata[`EAC_CTRL_MODE_MSB:`EAC_CTRL_MODE_LSB]);
  // strobe honoured only while already armed
  assign prog_go = ctrl_wr && io.io_wdata[`EAC_CTRL_PROG] && (arm_cnt_q != 3'h0) && !busy;
  // reads are refused while programming runs; programming wins a joint write
  assign read_go = ctrl_wr && io.io_wdata[`EAC_CTRL_READ] && !busy && !prog_go;

  // combine old cell, buffered byte and mode into the new cell value
  function automatic eac_byte_t commit(eac_mode_e m, eac_byte_t old, eac_byte_t nw);
    unique case (m)
      eac_mode_erase: commit = `EAC_ERASED;
      // write only can clear bits, never set them
      eac_mode_write: commit = old & nw;
      eac_mode_both: commit = nw;
      eac_mode_load: commit = old;
    endcase
  endfunction

  // no reset on the address register
  always_ff @(posedge clk) begin
    if (io.io_wr && io.io_addr == `EAC_OFS_ADDR_LO) begin
      addr_q[7:0] <= io.io_wdata;
    end
    if (io.io_wr && io.io_addr == `EAC_OFS_ADDR_HI) begin
      addr_q[AW-1:8] <= io.io_wdata[HW-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= `EAC_RST_DATA;
    end else if (read_go) begin
      // fetched byte lands in the data register
      data_q <= mem_q[addr_q];
    end else if (io.io_wr && io.io_addr == `EAC_OFS_DATA) begin
      data_q <= io.io_wdata;
    end
  end

  // mode is frozen while an operation runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= eac_mode_e'(`EAC_RST_MODE);
    end else if (ctrl_wr && !busy) begin
      mode_q <= wr_mode;
    end
  end

  // arm window counts down and expires
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_cnt_q <= 3'h0;
    end else if (prog_go) begin
      arm_cnt_q <= 3'h0;
    end else if (ctrl_wr && io.io_wdata[`EAC_CTRL_ARM] && !busy) begin
      arm_cnt_q <= `EAC_ARM_WINDOW;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_q <= 3'h0;
    end else if (read_go) begin
      stall_q <= `EAC_STALL_READ;
    end else if (prog_go) begin
      stall_q <= `EAC_STALL_PROG;
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // programming path
  // ----------------------------------------------------------------
  // system reset must reach the page buffer only through a synchroniser
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end else begin
      rst_meta_q <= resetn;
      rst_sync_q <= rst_meta_q;
    end
  end

  // last byte goes to the buffer at its address; page latched for commit
  always_ff @(posedge clk) begin
    if (prog_go) begin
      pbuf_q[addr_q[PW-1:0]] <= data_q;
      pg_q <= addr_q[AW-1:PW];
      run_mode_q <= wr_mode;
    end
  end

  // buffer survives system reset while an operation is running
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pvld_q <= '0;
    end else if (prog_go) begin
      pvld_q[addr_q[PW-1:0]] <= 1'h1;
    end else if (done && run_mode_q != eac_mode_load) begin
      pvld_q <= '0;
    end else if (!rst_sync_q && !busy) begin
      pvld_q <= '0;
    end
  end

  // commit selected operation to every buffered byte
  always_ff @(posedge clk) begin
    if (done && run_mode_q != eac_mode_load) begin
      for (int i = 0; i < PAGE; i++) begin
        if (pvld_q[i]) begin
          mem_q[{pg_q, PW'(i)}] <= commit(run_mode_q, mem_q[{pg_q, PW'(i)}], pbuf_q[i]);
        end
      end
    end
  end

  eac_prog_timer #(
    .OSC_DIV(OSC_DIV),
    .T_ERASE(T_ERASE_TICKS),
    .T_WRITE(T_WRITE_TICKS),
    .T_LOAD(T_LOAD_TICKS)
  ) u_timer (
    .clk(clk),
    .por_n(por_n),
    .start(prog_go),
    .mode(wr_mode),
    .busy(busy),
    .done(done)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    unique case (io.io_addr)
      // strobe bit mirrors the running operation
      `EAC_OFS_CTRL: begin
        rd_mux[`EAC_CTRL_MODE_MSB:`EAC_CTRL_MODE_LSB] = mode_q;
        rd_mux[`EAC_CTRL_ARM] = (arm_cnt_q != 3'h0);
        rd_mux[`EAC_CTRL_PROG] = busy;
      end
      `EAC_OFS_DATA: rd_mux = data_q;
      `EAC_OFS_ADDR_LO: rd_mux = addr_q[7:0];
      `EAC_OFS_ADDR_HI: rd_mux[HW-1:0] = addr_q[AW-1:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (io.io_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign io.io_rdata = rdata_q;
  assign io.io_stall = (stall_q != 3'h0);
  assign prog_busy = busy;
endmodule
`default_nettype wire

// ===== hdl/eac_cpu_host.sv
// core-side sequencer that drives the nv access controller registers
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
module eac_cpu_host import eac_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flash_busy,
  input wire logic [`EAC_SW_AW-1:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  eac_io_if.cpu io
);
  typedef enum logic [3:0] {
    hs_idle = 4'h0,
    hs_poll = 4'h1,
    hs_chk = 4'h3,
    hs_ahi = 4'h2,
    hs_alo = 4'h6,
    hs_dat = 4'h7,
    hs_arm = 4'h5,
    hs_go = 4'h4,
    hs_rdd = 4'hC,
    hs_cap = 4'hD
  } eac_host_st_e;

  eac_host_st_e st_q, st_d;
  logic [15:0] h_addr_q;
  eac_byte_t h_data_q, h_rbyte_q, sw_rdata_q;
  eac_mode_e h_mode_q;
  logic h_read_q, go_q, can_issue;
  logic wr_q, rd_q, wr_d, rd_d;
  logic [`EAC_IO_AW-1:0] adr_q, adr_d;
  eac_byte_t wd_q, wd_d;

  // control byte with arm, strobe and mode
  function automatic eac_byte_t ctrl_byte(eac_mode_e m, logic arm, logic prg, logic rd);
    ctrl_byte = 8'h00;
    ctrl_byte[`EAC_CTRL_MODE_MSB:`EAC_CTRL_MODE_LSB] = m;
    ctrl_byte[`EAC_CTRL_ARM] = arm;
    ctrl_byte[`EAC_CTRL_PROG] = prg;
    ctrl_byte[`EAC_CTRL_READ] = rd;
  endfunction

  // one gap cycle after each access lets a fresh stall become visible
  assign can_issue = !io.io_stall && !wr_q && !rd_q;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_addr_q <= 16'h0000;
      h_data_q <= 8'h00;
      h_mode_q <= eac_mode_both;
      h_read_q <= 1'h0;
      go_q <= 1'h0;
    end else begin
      if (sw_wr && sw_addr == `EAC_SW_ADDR_LO) h_addr_q[7:0] <= sw_wdata;
      if (sw_wr && sw_addr == `EAC_SW_ADDR_HI) h_addr_q[15:8] <= sw_wdata;
      if (sw_wr && sw_addr == `EAC_SW_DATA) h_data_q <= sw_wdata;
      // erase, write, combined and load are all separate commands
      if (sw_wr && sw_addr == `EAC_SW_CMD && st_q == hs_idle && !go_q) begin
        h_mode_q <= eac_mode_e'(sw_wdata[1:0]);
        h_read_q <= sw_wdata[`EAC_CMD_READ];
        go_q <= 1'h1;
      end else if (st_q == hs_idle && go_q) begin
        go_q <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_rdata_q <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        `EAC_SW_ADDR_LO: sw_rdata_q <= h_addr_q[7:0];
        `EAC_SW_ADDR_HI: sw_rdata_q <= h_addr_q[15:8];
        `EAC_SW_DATA: sw_rdata_q <= h_rbyte_q;
        `EAC_SW_STATUS: begin
          sw_rdata_q <= 8'h00;
          sw_rdata_q[`EAC_ST_BUSY] <= go_q || (st_q != hs_idle);
          sw_rdata_q[`EAC_ST_FLASH_WAIT] <= (st_q == hs_poll) && flash_busy && !h_read_q;
        end
        default: sw_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    wr_d = 1'h0;
    rd_d = 1'h0;
    adr_d = adr_q;
    wd_d = wd_q;
    unique case (st_q)
      hs_idle: if (go_q) st_d = hs_poll;
      // hold programming while flash self programming runs
      hs_poll: if (can_issue && !(flash_busy && !h_read_q)) begin
        rd_d = 1'h1;
        adr_d = `EAC_OFS_CTRL;
        st_d = hs_chk;
      end
      // repeat polling until the strobe reads clear
      hs_chk: if (!rd_q) st_d = io.io_rdata[`EAC_CTRL_PROG] ? hs_poll : hs_ahi;
      hs_ahi: if (can_issue) begin
        wr_d = 1'h1;
        adr_d = `EAC_OFS_ADDR_HI;
        wd_d = h_addr_q[15:8];
        st_d = hs_alo;
      end
      hs_alo: if (can_issue) begin
        wr_d = 1'h1;
        adr_d = `EAC_OFS_ADDR_LO;
        wd_d = h_addr_q[7:0];
        st_d = h_read_q ? hs_go : hs_dat;
      end
      hs_dat: if (can_issue) begin
        wr_d = 1'h1;
        adr_d = `EAC_OFS_DATA;
        wd_d = h_data_q;
        st_d = hs_arm;
      end
      // arm first with the mode chosen
      hs_arm: if (can_issue) begin
        wr_d = 1'h1;
        adr_d = `EAC_OFS_CTRL;
        wd_d = ctrl_byte(h_mode_q, 1'h1, 1'h0, 1'h0);
        st_d = hs_go;
      end
      // strobe follows the arm two cycles later, nothing in between
      hs_go: if (can_issue) begin
        wr_d = 1'h1;
        adr_d = `EAC_OFS_CTRL;
        wd_d = h_read_q ? ctrl_byte(h_mode_q, 1'h0, 1'h0, 1'h1)
                        : ctrl_byte(h_mode_q, 1'h1, 1'h1, 1'h0);
        st_d = h_read_q ? hs_rdd : hs_idle;
      end
      // fetch the byte once the read stall is over
      hs_rdd: if (can_issue) begin
        rd_d = 1'h1;
        adr_d = `EAC_OFS_DATA;
        st_d = hs_cap;
      end
      hs_cap: if (!rd_q) st_d = hs_idle;
      default: st_d = hs_idle;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= hs_idle;
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      adr_q <= '0;
      wd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      adr_q <= adr_d;
      wd_q <= wd_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_rbyte_q <= 8'h00;
    end else if (st_q == hs_cap && !rd_q) begin
      h_rbyte_q <= io.io_rdata;
    end
  end

  assign io.io_wr = wr_q;
  assign io.io_rd = rd_q;
  assign io.io_addr = adr_q;
  assign io.io_wdata = wd_q;
  assign sw_rdata = sw_rdata_q;
endmodule
`default_nettype wire

// ===== dv/eac_io_properties.sv
// concurrent checks on the io port between the core side and the nv controller
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
module eac_io_properties #(
  parameter int unsigned OSC_DIV = 2,
  parameter int unsigned T_WRITE_TICKS = 5,
  parameter int unsigned T_ERASE_TICKS = 9,
  parameter int unsigned T_LOAD_TICKS = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic [`EAC_IO_AW-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_stall,
  input wire logic prog_busy
);
  localparam int unsigned T_BOTH = T_WRITE_TICKS + T_ERASE_TICKS;
  logic ctrl_wr;
  logic ctrl_rd;
  logic start;
  logic [2:0] arm_q;
  logic [1:0] cmode_q;
  logic [1:0] mode_q;
  logic [15:0] len_q;
  assign ctrl_wr = io_wr && (io_addr == `EAC_OFS_CTRL);
  assign ctrl_rd = io_rd && (io_addr == `EAC_OFS_CTRL);
  assign start = ctrl_wr && io_wdata[`EAC_CTRL_PROG] && (arm_q != 3'h0) && !prog_busy;
  // ---------------------------------------------
  // shadow of arm window and mode field
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_q <= 3'h0;
    end else if (start) begin
      // a taken strobe uses up the arm, as in the controller
      arm_q <= 3'h0;
    end else if (ctrl_wr && io_wdata[`EAC_CTRL_ARM] && !prog_busy) begin
      arm_q <= `EAC_ARM_WINDOW;
    end else if (arm_q != 3'h0) begin
      arm_q <= arm_q - 3'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmode_q <= 2'h0;
    end else if (ctrl_wr && !prog_busy) begin
      cmode_q <= io_wdata[5:4];
    end
  end
  // only power-on clears this: a system reset must not hide a running operation
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      len_q <= 16'h0000;
      mode_q <= 2'h0;
    end else if (start) begin
      len_q <= 16'h0000;
      mode_q <= io_wdata[5:4];
    end else if (prog_busy) begin
      len_q <= len_q + 16'h0001;
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_stall: assert property (
    ctrl_wr && io_wdata[0] && !io_wdata[1] && !prog_busy |=> io_stall [*4] ##1 !io_stall)
    else $error("read stall length wrong");
  a_prog_stall: assert property (
    start |=> (io_stall && prog_busy) ##1 io_stall ##1 !io_stall)
    else $error("program stall or busy wrong");
  a_stall_cause: assert property ($rose(io_stall) |-> $past(ctrl_wr))
    else $error("stall without control write");
  a_armed_start: assert property ($rose(prog_busy) |-> $past(start))
    else $error("programming began without armed strobe");
  a_ctrl_busy: assert property (ctrl_rd |=> io_rdata[1] == $past(prog_busy))
    else $error("strobe bit does not show busy");
  a_ctrl_fields: assert property (
    ctrl_rd |=> io_rdata[5:4] == $past(cmode_q) && io_rdata[7:6] == 2'h0
      && io_rdata[3] == 1'b0 && io_rdata[0] == 1'b0)
    else $error("control read fields wrong");
  a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("read data moved without read");
  a_write_time: assert property (@(posedge clk) disable iff (!por_n)
    $fell(prog_busy) && mode_q == 2'h2
      |-> len_q inside {[T_WRITE_TICKS*OSC_DIV-1 : (T_WRITE_TICKS+1)*OSC_DIV]})
    else $error("write duration wrong");
  a_erase_time: assert property (@(posedge clk) disable iff (!por_n)
    $fell(prog_busy) && mode_q == 2'h1
      |-> len_q inside {[T_ERASE_TICKS*OSC_DIV-1 : (T_ERASE_TICKS+1)*OSC_DIV]})
    else $error("erase duration wrong");
  a_both_time: assert property (@(posedge clk) disable iff (!por_n)
    $fell(prog_busy) && mode_q == 2'h0
      |-> len_q inside {[T_BOTH*OSC_DIV-1 : (T_BOTH+1)*OSC_DIV]})
    else $error("combined duration wrong");
  a_load_time: assert property (@(posedge clk) disable iff (!por_n)
    $fell(prog_busy) && mode_q == 2'h3
      |-> len_q inside {[T_LOAD_TICKS*OSC_DIV-1 : (T_LOAD_TICKS+1)*OSC_DIV]})
    else $error("load duration wrong");
  c_read: cover property (ctrl_wr && io_wdata[0]);
  c_load: cover property (start && io_wdata[5:4] == 2'h3);
  c_both_done: cover property ($fell(prog_busy) && mode_q == 2'h0);
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench: host sequencer and nv controller joined back to back
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.svh"
module tb;
  logic clk;
  logic resetn;
  logic por_n;
  logic flash_busy;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata;
  logic [7:0] sw_rdata;
  logic sw_wr;
  logic sw_rd;
  logic prog_busy;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] mem [int];
  logic [7:0] pb [8];
  bit pv [8];
  eac_io_if io_if();
  // short oscillator tick and tick counts keep the run brief
  eac_nv_device #(.OSC_DIV(2), .T_WRITE_TICKS(5), .T_ERASE_TICKS(9), .T_LOAD_TICKS(1))
    i_eac_nv_device (.clk(clk), .resetn(resetn), .por_n(por_n), .io(io_if),
    .prog_busy(prog_busy));
  eac_cpu_host i_eac_cpu_host (.clk(clk), .resetn(resetn), .flash_busy(flash_busy),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .io(io_if));
  // checker defaults already match the shortened timing above
  eac_io_properties u_chk (.clk(clk), .resetn(resetn), .por_n(por_n), .io_addr(io_if.io_addr),
    .io_wr(io_if.io_wr), .io_rd(io_if.io_rd), .io_wdata(io_if.io_wdata),
    .io_rdata(io_if.io_rdata), .io_stall(io_if.io_stall), .prog_busy(prog_busy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end
  // ---------------------------------------------
  // bus tasks and reference model
  // ---------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic swr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      srd(`EAC_SW_STATUS, s);
      n++;
    end while (s[`EAC_ST_BUSY] !== 1'b0 && n < 300);
    if (n >= 300) chk(s, 8'h00);
  endtask
  function automatic void model_prog(int a, logic [7:0] d, logic [1:0] m);
    int k;
    pb[a % 8] = d;
    pv[a % 8] = 1'b1;
    // outside mode 3, every buffered byte of the page commits, then the buffer empties
    for (int i = 0; i < 8; i++) begin
      if (m != 2'h3 && pv[i]) begin
        k = (a & ~7) | i;
        case (m)
          2'h1: mem[k] = 8'hFF;
          2'h2: mem[k] = mem[k] & pb[i];
          default: mem[k] = pb[i];
        endcase
        pv[i] = 1'b0;
      end
    end
  endfunction
  task automatic set_up(input int a, input logic [7:0] d, input logic [7:0] cmd);
    swr(`EAC_SW_ADDR_LO, a[7:0]);
    swr(`EAC_SW_ADDR_HI, a[15:8]);
    swr(`EAC_SW_DATA, d);
    swr(`EAC_SW_CMD, cmd);
  endtask
  task automatic prog(input int a, input logic [7:0] d, input logic [1:0] m);
    set_up(a, d, {6'h00, m});
    wait_idle();
    model_prog(a, d, m);
  endtask
  task automatic rd(input int a);
    logic [7:0] d;
    set_up(a, 8'h00, 8'h04);
    wait_idle();
    srd(`EAC_SW_DATA, d);
    chk(d, mem[a]);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    int a;
    logic [7:0] d;
    logic [7:0] s;
    resetn = 1'b0;
    por_n = 1'b0;
    flash_busy = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    void'($urandom(21127));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      a = $urandom % 4096;
      d = 8'($urandom);
      prog(a, d, 2'h0);
      rd(a);
      prog(a, 8'h00, 2'h1);
      rd(a);
      prog(a, d, 2'h2);
      prog(a, 8'($urandom), 2'h2);
      rd(a);
    end
    a = ($urandom % 512) * 8;
    for (int i = 0; i < 7; i++) prog(a + i, 8'($urandom), 2'h3);
    prog(a + 7, 8'($urandom), 2'h0);
    for (int i = 0; i < 8; i++) rd(a + i);
    srd(`EAC_SW_ADDR_HI, s);
    chk(s, 8'((a + 7) >> 8));
    srd(`EAC_SW_DATA, s);
    swr(3'h7, 8'($urandom));
    srd(`EAC_SW_DATA, d);
    chk(d, s);
    // pending flash self programming must hold the write back
    a = $urandom % 4096;
    d = 8'($urandom);
    @(posedge clk);
    flash_busy <= 1'b1;
    set_up(a, d, 8'h00);
    repeat (40) @(posedge clk);
    srd(`EAC_SW_STATUS, s);
    chk({6'h00, s[1:0]}, 8'h03);
    chk({7'h00, prog_busy}, 8'h00);
    @(posedge clk);
    flash_busy <= 1'b0;
    wait_idle();
    model_prog(a, d, 2'h0);
    rd(a);
    // system reset during a write lets it finish
    a = $urandom % 4096;
    prog(a, 8'($urandom), 2'h0);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({7'h00, prog_busy}, 8'h01);
    rd(a);
    print_verdict();
  end
endmodule
`default_nettype wire
